// ===== rtl/pip_regs.v
// link-side interrupt flag, enable and page select register bank
// What this block does
// - set the cable power flag when the cable power sense input falls
// - cable power flag is 1 after hardware reset; writing 1 clears it
// - cable power flag with resume watch enable and inactive link raises link-on
// - a state time-out sets its flag and triggers a bus reset
// - state time-out flag is 0 after hardware reset; writing 1 clears it
// - time-out flag with resume watch enable and inactive link raises link-on
// - set port event flag on status change of any enabled port
// - with resume watch enable, resume start on any port sets port event flag
// - port event flag is 0 after hardware reset; writing 1 clears it
// - accelerated arbitration enable, reset 0, kept over bus reset, ignored in beta mode
// - multispeed concatenation enable, reset 0, kept over bus reset, ignored in beta mode
// - read-only legacy speed holds fastest legacy self-ID speed, capped at S400
// - read-only beta link bit follows the beta mode select pin
// - writable two-bit bridge field feeds self-ID, resets to 0
// - three-bit page index picks the page at indices 8 to 15, reset 0
// - four-bit port index picks the port, numbered from 0, reset 0
// - an unimplemented port reads its whole status page as zero
// - resume watch enable resets to 0; lets time-outs raise port event flag while the link is inactive
`timescale 1ns/1ps
`default_nettype none
`include "pip_defines.vh"

module pip_regs (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axil_awaddr,
	input wire [2:0] s_axil_awprot,
	input wire s_axil_awvalid,
	output reg s_axil_awready,
	input wire [31:0] s_axil_wdata,
	input wire [3:0] s_axil_wstrb,
	input wire s_axil_wvalid,
	output reg s_axil_wready,
	output reg [1:0] s_axil_bresp,
	output reg s_axil_bvalid,
	input wire s_axil_bready,
	input wire [7:0] s_axil_araddr,
	input wire [2:0] s_axil_arprot,
	input wire s_axil_arvalid,
	output reg s_axil_arready,
	output reg [31:0] s_axil_rdata,
	output reg [1:0] s_axil_rresp,
	output reg s_axil_rvalid,
	input wire s_axil_rready,
	input wire cable_power_sense_in,
	input wire link_active,
	input wire state_timeout,
	input wire bus_reset,
	input wire legacy_selfid_valid,
	input wire [2:0] legacy_selfid_speed,
	input wire beta_mode_select_pin,
	input wire [2:0] port_connected,
	input wire [2:0] port_bias,
	input wire [2:0] port_fault,
	input wire [2:0] port_resume_start,
	output reg link_on_output,
	output reg bus_reset_req,
	output reg accel_arb_active,
	output reg multispeed_concat_active,
	output reg [1:0] selfid_bridge,
	output reg [2:0] port_disable_out
);
	localparam RD_IDLE = 3'b001;
	localparam RD_FETCH = 3'b010;
	localparam RD_RESP = 3'b100;

	reg cable_power_irq_r;
	reg state_timeout_irq_r;
	reg port_event_irq_r;
	reg resume_watch_irq_enable_r;
	reg accel_arb_enable_r;
	reg multispeed_concat_enable_r;
	reg [1:0] bridge_r;
	reg [2:0] legacy_path_max_speed_r;
	reg [2:0] page_r;
	reg [3:0] port_r;
	reg sense_prev_r;
	reg [3:0] stat_prev_r [0:2];

	reg aw_hold_r;
	reg w_hold_r;
	reg [7:0] aw_addr_r;
	reg [7:0] w_data_r;
	reg w_strb_r;
	reg [2:0] rd_state_r;
	reg [2:0] rd_state_nxt;
	reg [7:0] rd_addr_r;
	reg [7:0] base_rdata_nxt;
	reg [2:0] port_ev;

	wire [2:0] port_disable;
	wire [2:0] port_irq_en;
	wire [7:0] page_rdata;

	wire aw_take = s_axil_awvalid & s_axil_awready;
	wire w_take = s_axil_wvalid & s_axil_wready;
	wire do_write = aw_hold_r & w_hold_r & ~s_axil_bvalid;
	wire aw_hold_nxt = (aw_hold_r & ~do_write) | aw_take;
	wire w_hold_nxt = (w_hold_r & ~do_write) | w_take;
	wire [3:0] wr_idx = aw_addr_r[5:2];
	wire wr_ok = (aw_addr_r[7:6] == `PIP_UPPER_ZERO) & w_strb_r;
	wire wr_base = do_write & wr_ok;
	wire ar_take = s_axil_arvalid & s_axil_arready;
	wire [3:0] ar_idx = s_axil_araddr[5:2];
	wire [3:0] rd_idx = rd_addr_r[5:2];
	wire rd_in_page = rd_idx[`PIP_IDX_PAGE_BIT];
	wire rd_mapped = (rd_addr_r[7:6] == `PIP_UPPER_ZERO) &&
		(rd_in_page || rd_idx == `PIP_IDX_IRQ || rd_idx == `PIP_IDX_CTRL ||
		rd_idx == `PIP_IDX_SEL);
	wire wr_mapped = (aw_addr_r[7:6] == `PIP_UPPER_ZERO) &&
		(wr_idx[`PIP_IDX_PAGE_BIT] || wr_idx == `PIP_IDX_IRQ ||
		wr_idx == `PIP_IDX_CTRL || wr_idx == `PIP_IDX_SEL);
	// the port page only answers on page 0 for a real port
	wire page_ok = (page_r == `PIP_PAGE_PORT_STATUS) && (port_r < `PIP_NUM_PORTS_C);
	wire page_wr = wr_base & wr_idx[`PIP_IDX_PAGE_BIT] & page_ok;
	wire w1c = wr_base & (wr_idx == `PIP_IDX_IRQ);
	wire link_idle = ~link_active;

	wire cable_fall = sense_prev_r & ~cable_power_sense_in;
	wire watch_hit = resume_watch_irq_enable_r & link_idle &
		(cable_power_irq_r | state_timeout_irq_r);
	wire port_set = (|port_ev) | (resume_watch_irq_enable_r & (|port_resume_start)) |
		watch_hit;

	pip_port_page u_page (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(page_wr),
		.wr_idx(wr_idx),
		.wr_port(port_r),
		.wr_data(w_data_r),
		.rd_en(ar_take),
		.rd_idx(ar_idx),
		.rd_port(port_r),
		.rd_page_ok(page_ok),
		.port_connected(port_connected),
		.port_bias(port_bias),
		.port_fault(port_fault),
		.port_disable(port_disable),
		.port_irq_en(port_irq_en),
		.rd_data_r(page_rdata)
	);

	// change of connected, bias, disabled or fault on an enabled port
	genvar g;
	generate
		for (g = 0; g < `PIP_NUM_PORTS; g = g + 1) begin : g_ev
			wire [3:0] stat_now = {port_fault[g], port_bias[g], port_connected[g],
				port_disable[g]};
			always @* begin
				port_ev[g] = port_irq_en[g] & (stat_now != stat_prev_r[g]);
			end
			always @(posedge aclk) begin
				if (!aresetn)
					stat_prev_r[g] <= {`PIP_RST_BIT, `PIP_RST_BIT, `PIP_RST_BIT,
						`PIP_RST_BIT};
				else
					stat_prev_r[g] <= stat_now;
			end
		end
	endgenerate

	// flags: hardware set wins over a same-cycle write-one clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			cable_power_irq_r <= `PIP_RST_CABLE_IRQ;
			state_timeout_irq_r <= `PIP_RST_TIMEOUT_IRQ;
			port_event_irq_r <= `PIP_RST_PORT_IRQ;
			sense_prev_r <= `PIP_RST_BIT;
		end else begin
			sense_prev_r <= cable_power_sense_in;
			cable_power_irq_r <= cable_fall | (cable_power_irq_r &
				~(w1c & w_data_r[`PIP_IRQ_CABLE]));
			state_timeout_irq_r <= state_timeout | (state_timeout_irq_r &
				~(w1c & w_data_r[`PIP_IRQ_TIMEOUT]));
			port_event_irq_r <= port_set | (port_event_irq_r &
				~(w1c & w_data_r[`PIP_IRQ_PORT]));
		end
	end

	// software fields; bus reset leaves all of these alone
	always @(posedge aclk) begin
		if (!aresetn) begin
			resume_watch_irq_enable_r <= `PIP_RST_BIT;
			accel_arb_enable_r <= `PIP_RST_BIT;
			multispeed_concat_enable_r <= `PIP_RST_BIT;
			bridge_r <= `PIP_RST_BRIDGE;
			page_r <= `PIP_RST_PAGE;
			port_r <= `PIP_RST_PORT;
		end else if (wr_base) begin
			if (wr_idx == `PIP_IDX_IRQ)
				resume_watch_irq_enable_r <= w_data_r[`PIP_IRQ_WATCH_EN];
			if (wr_idx == `PIP_IDX_CTRL) begin
				accel_arb_enable_r <= w_data_r[`PIP_CTRL_ACCEL];
				multispeed_concat_enable_r <= w_data_r[`PIP_CTRL_MULTI];
				bridge_r <= w_data_r[`PIP_CTRL_BRIDGE_HI:`PIP_CTRL_BRIDGE_LO];
			end
			if (wr_idx == `PIP_IDX_SEL) begin
				page_r <= w_data_r[`PIP_SEL_PAGE_HI:`PIP_SEL_PAGE_LO];
				port_r <= w_data_r[`PIP_SEL_PORT_HI:`PIP_SEL_PORT_LO];
			end
		end
	end

	// fastest legacy node seen since the last bus reset, never above S400
	always @(posedge aclk) begin
		if (!aresetn || bus_reset)
			legacy_path_max_speed_r <= `PIP_RST_SPEED;
		else if (legacy_selfid_valid && legacy_selfid_speed > legacy_path_max_speed_r)
			legacy_path_max_speed_r <= (legacy_selfid_speed > `PIP_SPD_S400) ?
				`PIP_SPD_S400 : legacy_selfid_speed;
	end

	// outputs toward the core; beta mode masks the legacy arbitration features
	always @(posedge aclk) begin
		if (!aresetn) begin
			link_on_output <= `PIP_RST_BIT;
			bus_reset_req <= `PIP_RST_BIT;
			accel_arb_active <= `PIP_RST_BIT;
			multispeed_concat_active <= `PIP_RST_BIT;
			selfid_bridge <= `PIP_RST_BRIDGE;
			port_disable_out <= {`PIP_RST_BIT, `PIP_RST_BIT, `PIP_RST_BIT};
		end else begin
			link_on_output <= resume_watch_irq_enable_r & link_idle &
				(cable_power_irq_r | state_timeout_irq_r);
			bus_reset_req <= state_timeout;
			accel_arb_active <= accel_arb_enable_r & ~beta_mode_select_pin;
			multispeed_concat_active <= multispeed_concat_enable_r &
				~beta_mode_select_pin;
			selfid_bridge <= bridge_r;
			port_disable_out <= port_disable;
		end
	end

	// write channel: address and data taken in either order, one write at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= `PIP_RST_BIT;
			w_hold_r <= `PIP_RST_BIT;
			s_axil_awready <= `PIP_RST_BIT;
			s_axil_wready <= `PIP_RST_BIT;
			s_axil_bvalid <= `PIP_RST_BIT;
			s_axil_bresp <= `PIP_RESP_OKAY;
			aw_addr_r <= `PIP_RST_BYTE;
			w_data_r <= `PIP_RST_BYTE;
			w_strb_r <= `PIP_RST_BIT;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			s_axil_awready <= ~aw_hold_nxt;
			s_axil_wready <= ~w_hold_nxt;
			if (aw_take)
				aw_addr_r <= s_axil_awaddr;
			if (w_take) begin
				w_data_r <= s_axil_wdata[7:0];
				w_strb_r <= s_axil_wstrb[0];
			end
			if (do_write) begin
				s_axil_bvalid <= 1'b1;
				s_axil_bresp <= wr_mapped ? `PIP_RESP_OKAY : `PIP_RESP_SLVERR;
			end else if (s_axil_bready)
				s_axil_bvalid <= 1'b0;
		end
	end

	// base register read image, sampled in the fetch cycle, one cycle after the page memory
	always @* begin
		base_rdata_nxt = `PIP_RST_BYTE;
		case (rd_idx)
		`PIP_IDX_IRQ: begin
			base_rdata_nxt[`PIP_IRQ_CABLE] = cable_power_irq_r;
			base_rdata_nxt[`PIP_IRQ_TIMEOUT] = state_timeout_irq_r;
			base_rdata_nxt[`PIP_IRQ_PORT] = port_event_irq_r;
			base_rdata_nxt[`PIP_IRQ_WATCH_EN] = resume_watch_irq_enable_r;
		end
		`PIP_IDX_CTRL: begin
			base_rdata_nxt[`PIP_CTRL_ACCEL] = accel_arb_enable_r;
			base_rdata_nxt[`PIP_CTRL_MULTI] = multispeed_concat_enable_r;
			base_rdata_nxt[`PIP_CTRL_BRIDGE_HI:`PIP_CTRL_BRIDGE_LO] = bridge_r;
			base_rdata_nxt[`PIP_CTRL_LEG_HI:`PIP_CTRL_LEG_LO] = legacy_path_max_speed_r;
			base_rdata_nxt[`PIP_CTRL_BETA] = beta_mode_select_pin;
		end
		`PIP_IDX_SEL: begin
			base_rdata_nxt[`PIP_SEL_PAGE_HI:`PIP_SEL_PAGE_LO] = page_r;
			base_rdata_nxt[`PIP_SEL_PORT_HI:`PIP_SEL_PORT_LO] = port_r;
		end
		default: base_rdata_nxt = `PIP_RST_BYTE;
		endcase
	end

	// read path: one cycle to fetch so page data comes from a register
	always @* begin
		case (rd_state_r)
		RD_IDLE: rd_state_nxt = ar_take ? RD_FETCH : RD_IDLE;
		RD_FETCH: rd_state_nxt = RD_RESP;
		RD_RESP: rd_state_nxt = s_axil_rready ? RD_IDLE : RD_RESP;
		default: rd_state_nxt = RD_IDLE;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_r <= RD_IDLE;
			rd_addr_r <= `PIP_RST_BYTE;
			s_axil_arready <= `PIP_RST_BIT;
			s_axil_rvalid <= `PIP_RST_BIT;
			s_axil_rdata <= `PIP_RST_WORD;
			s_axil_rresp <= `PIP_RESP_OKAY;
		end else begin
			rd_state_r <= rd_state_nxt;
			s_axil_arready <= (rd_state_nxt == RD_IDLE);
			if (ar_take)
				rd_addr_r <= s_axil_araddr;
			// page memory was read at the take, so both images are ready here;
			// loaded once so the word stands while rvalid waits on rready
			if (rd_state_r == RD_FETCH)
				s_axil_rdata <= {24'h00_0000, rd_mapped ?
					(rd_in_page ? page_rdata : base_rdata_nxt) : `PIP_RST_BYTE};
			if (rd_state_nxt == RD_RESP && rd_state_r == RD_FETCH) begin
				s_axil_rvalid <= 1'b1;
				s_axil_rresp <= rd_mapped ? `PIP_RESP_OKAY : `PIP_RESP_SLVERR;
			end else if (rd_state_r == RD_RESP && s_axil_rready)
				s_axil_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== shared/pip_defines.vh
// constants for the link-side interrupt, enable and page select register bank
`ifndef PIP_DEFINES_VH
`define PIP_DEFINES_VH

`define PIP_ADDR_W 8
`define PIP_DATA_W 32
`define PIP_NUM_PORTS 3
`define PIP_PORT_NUM_W 4
`define PIP_NUM_PORTS_C 4'h3

// register indices; byte address is four times the index
`define PIP_IDX_IRQ 4'h5
`define PIP_IDX_CTRL 4'h6
`define PIP_IDX_SEL 4'h7
`define PIP_IDX_STAT 4'h8
`define PIP_IDX_PEN 4'h9
`define PIP_IDX_PAGE_BIT 3
`define PIP_UPPER_ZERO 2'h0

// interrupt register fields
`define PIP_IRQ_CABLE 0
`define PIP_IRQ_TIMEOUT 1
`define PIP_IRQ_PORT 2
`define PIP_IRQ_WATCH_EN 3

// control register fields
`define PIP_CTRL_ACCEL 0
`define PIP_CTRL_MULTI 1
`define PIP_CTRL_BRIDGE_LO 2
`define PIP_CTRL_BRIDGE_HI 3
`define PIP_CTRL_LEG_LO 4
`define PIP_CTRL_LEG_HI 6
`define PIP_CTRL_BETA 7

// page and port index fields
`define PIP_SEL_PORT_LO 0
`define PIP_SEL_PORT_HI 3
`define PIP_SEL_PAGE_LO 5
`define PIP_SEL_PAGE_HI 7
`define PIP_PAGE_PORT_STATUS 3'h0

// port status page fields (index 8 and 9)
`define PIP_PS_DIS 0
`define PIP_PS_CONN 1
`define PIP_PS_BIAS 2
`define PIP_PS_FAULT 3
`define PIP_PE_EN 0

// reset values
`define PIP_RST_CABLE_IRQ 1'h1
`define PIP_RST_TIMEOUT_IRQ 1'h0
`define PIP_RST_PORT_IRQ 1'h0
`define PIP_RST_BIT 1'h0
`define PIP_RST_BRIDGE 2'h0
`define PIP_RST_SPEED 3'h0
`define PIP_RST_PAGE 3'h0
`define PIP_RST_PORT 4'h0
`define PIP_RST_BYTE 8'h00
`define PIP_RST_WORD 32'h0000_0000

`define PIP_SPD_S400 3'h2
`define PIP_RESP_OKAY 2'h0
`define PIP_RESP_SLVERR 2'h2

`endif

// ===== rtl/pip_port_page.v
// per-port status page storage with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "pip_defines.vh"

module pip_port_page (
	input wire aclk,
	input wire aresetn,
	input wire wr_en,
	input wire [3:0] wr_idx,
	input wire [3:0] wr_port,
	input wire [7:0] wr_data,
	input wire rd_en,
	input wire [3:0] rd_idx,
	input wire [3:0] rd_port,
	input wire rd_page_ok,
	input wire [2:0] port_connected,
	input wire [2:0] port_bias,
	input wire [2:0] port_fault,
	output wire [2:0] port_disable,
	output wire [2:0] port_irq_en,
	output reg [7:0] rd_data_r
);
	reg [2:0] dis_r;
	reg [2:0] pen_r;
	reg [7:0] rd_nxt;
	integer i;

	assign port_disable = dis_r;
	assign port_irq_en = pen_r;

	genvar g;
	generate
		for (g = 0; g < `PIP_NUM_PORTS; g = g + 1) begin : g_port
			always @(posedge aclk) begin
				if (!aresetn) begin
					dis_r[g] <= `PIP_RST_BIT;
					pen_r[g] <= `PIP_RST_BIT;
				end else if (wr_en && wr_port == g) begin
					if (wr_idx == `PIP_IDX_STAT)
						dis_r[g] <= wr_data[`PIP_PS_DIS];
					if (wr_idx == `PIP_IDX_PEN)
						pen_r[g] <= wr_data[`PIP_PE_EN];
				end
			end
		end
	endgenerate

	// unimplemented ports and pages read back as all zero
	always @* begin
		rd_nxt = `PIP_RST_BYTE;
		for (i = 0; i < `PIP_NUM_PORTS; i = i + 1) begin
			if (rd_page_ok && rd_port == i) begin
				if (rd_idx == `PIP_IDX_STAT) begin
					rd_nxt[`PIP_PS_DIS] = dis_r[i];
					rd_nxt[`PIP_PS_CONN] = port_connected[i];
					rd_nxt[`PIP_PS_BIAS] = port_bias[i];
					rd_nxt[`PIP_PS_FAULT] = port_fault[i];
				end
				if (rd_idx == `PIP_IDX_PEN)
					rd_nxt[`PIP_PE_EN] = pen_r[i];
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn)
			rd_data_r <= `PIP_RST_BYTE;
		else if (rd_en)
			rd_data_r <= rd_nxt;
	end
endmodule
`default_nettype wire

// ===== tb/pip_regs_asserts.sv
// checker for the register bank ports
`timescale 1ns/1ps
`default_nettype none
module pip_regs_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axil_awvalid,
	input wire logic s_axil_awready,
	input wire logic s_axil_wvalid,
	input wire logic s_axil_wready,
	input wire logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [1:0] s_axil_bresp,
	input wire logic s_axil_arvalid,
	input wire logic s_axil_arready,
	input wire logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic [31:0] s_axil_rdata,
	input wire logic state_timeout,
	input wire logic bus_reset_req,
	input wire logic link_active,
	input wire logic link_on_output,
	input wire logic beta_mode_select_pin,
	input wire logic accel_arb_active,
	input wire logic multispeed_concat_active
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_TMO_BUS_RESET: assert property (state_timeout |=> bus_reset_req)
		else $error("no bus reset request after time-out");
	AST_LINK_ON_IDLE: assert property ($past(link_active) |-> !link_on_output)
		else $error("link-on raised while link active");
	AST_ACCEL_BETA: assert property ($past(beta_mode_select_pin) |-> !accel_arb_active)
		else $error("accelerated arbitration active in beta mode");
	AST_MULTI_BETA: assert property ($past(beta_mode_select_pin) |-> !multispeed_concat_active)
		else $error("multispeed concatenation active in beta mode");
	AST_RD_LATENCY: assert property (s_axil_arvalid && s_axil_arready |-> ##2 s_axil_rvalid)
		else $error("read answer late");
	AST_WR_LATENCY: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid
		&& s_axil_wready |-> ##2 s_axil_bvalid)
		else $error("write answer late");
	AST_R_HOLD: assert property (s_axil_rvalid && !s_axil_rready |=>
		s_axil_rvalid && $stable(s_axil_rdata))
		else $error("read data dropped before taken");
	AST_B_HOLD: assert property (s_axil_bvalid && !s_axil_bready |=>
		s_axil_bvalid && $stable(s_axil_bresp))
		else $error("write response dropped before taken");
	AST_R_UPPER: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
endmodule
`default_nettype wire

// ===== tb/pip_link_model.sv
// link controller model: wakes when asked by link-on
`timescale 1ns/1ps
`default_nettype none
module pip_link_model #(
	parameter int WAKE_DLY = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic link_on_output,
	input wire logic go_idle,
	output var logic link_active
);
	logic [3:0] cnt_r;
	// slow wake so link-on is seen held for several cycles
	always @(posedge aclk) begin
		if (!aresetn) begin
			link_active <= 1'b0;
			cnt_r <= 4'h0;
		end else if (go_idle) begin
			link_active <= 1'b0;
		end else if (link_on_output && !link_active) begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == WAKE_DLY) begin
				link_active <= 1'b1;
				cnt_r <= 4'h0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// bench for the interrupt, enable and page select registers
`timescale 1ns/1ps
`default_nettype none
`include "pip_defines.vh"
module testbench;
	logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
	logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
	logic s_axil_rready, cable_power_sense_in, link_active, state_timeout, bus_reset;
	logic legacy_selfid_valid, beta_mode_select_pin, link_on_output, bus_reset_req;
	logic accel_arb_active, multispeed_concat_active, go_idle;
	logic [7:0] s_axil_awaddr, s_axil_araddr;
	logic [2:0] s_axil_awprot, s_axil_arprot, legacy_selfid_speed, port_connected;
	logic [2:0] port_bias, port_fault, port_resume_start, port_disable_out;
	logic [31:0] s_axil_wdata, s_axil_rdata;
	logic [3:0] s_axil_wstrb;
	logic [1:0] s_axil_bresp, s_axil_rresp, selfid_bridge;
	int fail_count = 0;
	int compares = 0;
	pip_regs dut (.*);
	pip_link_model lnk (.*);
	task automatic results;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [3:0] i, input logic [7:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axil_awaddr <= {2'h0, i, 2'h0};
		s_axil_wdata <= {24'h000000, d};
		s_axil_awvalid <= 1'b1;
		s_axil_wvalid <= 1'b1;
		s_axil_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axil_awready) s_axil_awvalid <= 1'b0;
			if (s_axil_wready) s_axil_wvalid <= 1'b0;
		end while (!s_axil_bvalid);
		s_axil_bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, s_axil_bresp});
	endtask
	task automatic rd(input logic [3:0] i, input logic [7:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axil_araddr <= {2'h0, i, 2'h0};
		s_axil_arvalid <= 1'b1;
		s_axil_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axil_arready) s_axil_arvalid <= 1'b0;
		end while (!s_axil_rvalid);
		s_axil_rready <= 1'b0;
		chk("rdata", {24'h0, e}, s_axil_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axil_rresp});
	endtask
	task automatic wait_on(input logic v);
		int k;
		for (k = 0; k < 20 && link_on_output !== v; k++) @(posedge aclk);
		chk("link_on", {31'h0, v}, {31'h0, link_on_output});
	endtask
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	initial begin
		{aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid} = '0;
		{s_axil_rready, state_timeout, bus_reset, legacy_selfid_valid, go_idle} = '0;
		{beta_mode_select_pin, s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
		{s_axil_awprot, s_axil_arprot, legacy_selfid_speed, port_connected} = '0;
		{port_bias, port_fault, port_resume_start} = '0;
		s_axil_wstrb = 4'hF;
		cable_power_sense_in = 1'b1;
		step(3);
		aresetn <= 1'b1;
		rd(5, 8'h01, 2'h0);
		rd(6, 8'h00, 2'h0);
		rd(7, 8'h00, 2'h0);
		wr(5, 8'h00, 2'h0);
		rd(5, 8'h01, 2'h0);
		wr(5, 8'h01, 2'h0);
		rd(5, 8'h00, 2'h0);
		cable_power_sense_in <= 1'b0;
		step(2);
		rd(5, 8'h01, 2'h0);
		cable_power_sense_in <= 1'b1;
		wr(5, 8'h08, 2'h0);
		wait_on(1'b1);
		wait (link_active === 1'b1);
		step(2);
		chk("link_on", 32'h0, {31'h0, link_on_output});
		wr(5, 8'h0F, 2'h0);
		rd(5, 8'h08, 2'h0);
		state_timeout <= 1'b1;
		step(1);
		state_timeout <= 1'b0;
		rd(5, 8'h0A, 2'h0);
		go_idle <= 1'b1;
		step(1);
		go_idle <= 1'b0;
		wait_on(1'b1);
		wait (link_active === 1'b1);
		wr(5, 8'h0F, 2'h0);
		rd(5, 8'h08, 2'h0);
		port_resume_start <= 3'h4;
		step(1);
		port_resume_start <= 3'h0;
		rd(5, 8'h0C, 2'h0);
		wr(5, 8'h04, 2'h0);
		rd(5, 8'h00, 2'h0);
		wr(7, 8'h01, 2'h0);
		wr(9, 8'h01, 2'h0);
		port_connected <= 3'h2;
		step(2);
		rd(5, 8'h04, 2'h0);
		rd(8, 8'h02, 2'h0);
		wr(5, 8'h04, 2'h0);
		port_bias <= 3'h1;
		step(2);
		rd(5, 8'h00, 2'h0);
		wr(7, 8'h03, 2'h0);
		rd(8, 8'h00, 2'h0);
		rd(9, 8'h00, 2'h0);
		wr(7, 8'h20, 2'h0);
		rd(8, 8'h00, 2'h0);
		rd(7, 8'h20, 2'h0);
		wr(6, 8'h0F, 2'h0);
		bus_reset <= 1'b1;
		step(1);
		bus_reset <= 1'b0;
		step(1);
		chk("enables", 32'hF, {28'h0, selfid_bridge, multispeed_concat_active,
			accel_arb_active});
		beta_mode_select_pin <= 1'b1;
		step(2);
		chk("beta_masked", 32'h0, {31'h0, accel_arb_active | multispeed_concat_active});
		wr(6, 8'hF3, 2'h0);
		rd(6, 8'h83, 2'h0);
		legacy_selfid_speed <= 3'h5;
		legacy_selfid_valid <= 1'b1;
		step(1);
		legacy_selfid_speed <= 3'h1;
		step(1);
		legacy_selfid_valid <= 1'b0;
		rd(6, 8'hA3, 2'h0);
		wr(0, 8'hFF, `PIP_RESP_SLVERR);
		rd(0, 8'h00, `PIP_RESP_SLVERR);
		results;
	end
	initial begin
		repeat (5000) @(posedge aclk);
		fail_count++;
		results;
	end
endmodule
bind pip_regs pip_regs_asserts chk_i (.*);
`default_nettype wire
